// >>> design/vmfs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module vmfs_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Fill side.
  input  wire logic                         in_valid,
  input  wire logic [W-1:0]                 in_data,
  output logic                              in_ready,
  // Drain side.
  output logic                              out_valid,
  output logic [W-1:0]                      out_data,
  input  wire logic                         out_ready,
  // Occupancy.
  output logic [$clog2(DEPTH+1)-1:0]        count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] P_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] C_FULL = CW'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != C_FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q        <= (wr_q == P_LAST) ? '0 : PW'(wr_q + 1'b1);
      end
      if (pop)
        rd_q <= (rd_q == P_LAST) ? '0 : PW'(rd_q + 1'b1);
      if (push && !pop)
        cnt_q <= CW'(cnt_q + 1'b1);
      else if (pop && !push)
        cnt_q <= CW'(cnt_q - 1'b1);
    end
  end
endmodule
`default_nettype wire

// >>> design/vmfs_pkg.sv
// Constants, field layouts and helpers shared by the video memory fetch sequencer.
// Assumes a single 25 MHz core clock and a synchronous active-low reset.
`default_nettype none
package vmfs_pkg;
  // Bus and buffer sizes.
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 16;
  localparam int NARROW_W    = 8;
  localparam int FIFO_DEPTH  = 4;
  localparam int BUF_DEPTH   = 2;
  localparam int ENTRY_W     = DATA_W + 1;
  // Access slots per instruction cycle and clocks per instruction cycle.
  localparam int SLOTS_PER_INSTR = 3;
  localparam int INSTR_CLKS      = 5;
  localparam logic [2:0] IC_LAST    = 3'(INSTR_CLKS - 1);
  localparam logic [2:0] SLOT_LIMIT = 3'(SLOTS_PER_INSTR);
  localparam logic [2:0] FIFO_FULL_OCC = 3'(FIFO_DEPTH);
  // Timing chain indices.
  localparam logic [3:0] TC_HLEN       = 4'h0;
  localparam logic [3:0] TC_HDISP      = 4'h1;
  localparam logic [3:0] TC_HSYNC_BEG  = 4'h2;
  localparam logic [3:0] TC_HSYNC_END  = 4'h3;
  localparam logic [3:0] TC_CHAR_HGT   = 4'h4;
  localparam logic [3:0] TC_DISP_ROWS  = 4'h6;
  localparam logic [3:0] TC_STATUS_ROW = 4'h8;
  // Field positions inside the character height entry.
  localparam int CSH_MSB = 7;
  localparam int CSH_LSB = 4;
  localparam int ES_MSB  = 3;
  localparam int ES_LSB  = 0;
  // Pointer selects.
  localparam logic [2:0] PTR_HOME   = 3'h0;
  localparam logic [2:0] PTR_WBEG   = 3'h1;
  localparam logic [2:0] PTR_WEND   = 3'h2;
  localparam logic [2:0] PTR_CURSOR = 3'h3;
  localparam logic [2:0] PTR_STATUS = 3'h4;
  // System control bits.
  localparam int SCR_MUX_BIT   = 4;
  localparam int SCR_TABLE_BIT = 5;
  // Reset values.
  localparam logic [15:0] RST_PTR   = 16'h0000;
  localparam logic [6:0]  RST_HLEN  = 7'h4f;
  localparam logic [6:0]  RST_HDISP = 7'h3f;
  localparam logic [6:0]  RST_HSB   = 7'h44;
  localparam logic [6:0]  RST_HSE   = 7'h4a;
  localparam logic [3:0]  RST_CSH   = 4'h9;
  localparam logic [3:0]  RST_ES    = 4'h9;
  localparam logic [4:0]  RST_ROWS  = 5'h17;
  localparam logic [4:0]  RST_SRB   = 5'h1f;
  localparam logic [7:0]  RST_SCR   = 8'h00;

  typedef enum logic [2:0] {
    FS_IDLE  = 3'b001,
    FS_FETCH = 3'b010,
    FS_DONE  = 3'b100
  } vmfs_fetch_e;

  // Next sequential address, jumping to the wrap start when the wrap end is reached.
  function automatic logic [15:0] vmfs_next_addr(input logic [15:0] a,
                                                 input logic [15:0] wend,
                                                 input logic [15:0] wbeg);
    logic [15:0] n;
    n = 16'(a + 16'h0001);
    return (n == wend) ? wbeg : n;
  endfunction
endpackage
`default_nettype wire

// >>> design/vmfs_sequencer.sv
// Video memory fetch sequencer: slot arbiter, display fetch engine, pointers and timing fields.
// Assumes external video memory returns read data within the same clock as the address cycle.
// What this block does
// (RQ1) At most three memory accesses per instruction cycle.
// (RQ2) Drive a 16-bit video memory address.
// (RQ3) Data words 8 bits, or 16 with attributes.
// (RQ4) System control bit 4 selects bus multiplexing.
// (RQ5) Display fetch wins slots; CPU takes leftovers.
// (RQ6) CPU waits while no slot is granted.
// (RQ7) Four-entry display FIFO kept filled ahead.
// (RQ8) 16-bit pointers move whole through accumulator pair.
// (RQ9) System control bit 5 selects sequential or lookup.
// (RQ10) Pointer access kinds per register as listed.
// (RQ11) Field starts at display start, then consecutive.
// (RQ12) Reaching wrap end reloads from wrap start.
// (RQ13) Software sets wrap end last plus one.
// (RQ14) Flag fetched character matching the cursor pointer.
// (RQ15) Status row reloads fetch address from status pointer; in table mode the code reloads every row from the home pointer instead.
// (RQ16) Seven-bit sync end position, software loads count+2.
// (RQ17) Sync toggles at begin and end positions.
// (RQ18) Four-bit character height, lines minus one.
// (RQ19) Extra scans minus one; equal height adds none.
// (RQ20) Five-bit status row begin, position minus one.
// (RQ21) Row end updates row start, raises row event.
// (RQ22) Request next fetch whenever FIFO has room.
`timescale 1ns/1ps
`default_nettype none
module vmfs_sequencer
  import vmfs_pkg::*;
(
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // System control register write.
  input  wire logic                scr_wr,
  input  wire logic [7:0]          scr_data,
  input  wire logic                attr_ext_en,
  // Pointer access through the accumulator pair.
  input  wire logic                ptr_wr,
  input  wire logic                ptr_rd,
  input  wire logic                cursor_inc,
  input  wire logic                cursor_dec,
  input  wire logic [2:0]          ptr_sel,
  input  wire logic [7:0]          high_accumulator,
  input  wire logic [7:0]          accumulator,
  output logic [15:0]              ptr_rdata,
  // Timing chain write.
  input  wire logic                tc_wr,
  input  wire logic [3:0]          timing_chain_index,
  input  wire logic [7:0]          tc_data,
  // CPU video memory request.
  input  wire logic                cpu_req,
  input  wire logic                cpu_we,
  input  wire logic [15:0]         cpu_addr,
  input  wire logic [15:0]         cpu_wdata,
  output logic                     cpu_wait,
  output logic                     cpu_ack,
  output logic [15:0]              cpu_rdata,
  // Video memory bus.
  output logic [15:0]              mem_addr,
  output logic                     mem_rd,
  output logic                     mem_wr,
  output logic [15:0]              mem_wdata,
  input  wire logic [15:0]         mem_rdata,
  output logic                     mem_wide,
  output logic                     mem_mux_mode,
  // Video controller side.
  input  wire logic                field_start,
  output logic                     vid_valid,
  output logic [15:0]              vid_data,
  output logic                     vid_cursor,
  input  wire logic                vid_ready,
  output logic                     row_end_event,
  // Horizontal and vertical timing outputs.
  output logic                     hsync,
  output logic [3:0]               scan_line,
  output logic [4:0]               extra_scans
);
  logic [7:0]  scr_q;
  logic [15:0] home_q, wbeg_q, wend_q, cursor_q, status_q, row_start_q, fetch_ptr_q;
  logic [6:0]  hlen_q, hdisp_q, hsb_q, hse_q, h_cnt_q, chr_cnt_q;
  logic [3:0]  csh_q, es_q, scan_cnt_q, scan_line_q;
  logic [4:0]  rows_q, srb_q, row_cnt_q, extra_q;
  logic [2:0]  ic_q;
  logic [15:0] ptr_rdata_q, cpu_rdata_q, mem_addr_q, mem_wdata_q;
  logic        mem_rd_q, mem_wr_q, pend_fetch_q, pend_cur_q, pend_cpu_q, cpu_ack_q;
  logic        hsync_q, row_end_q;
  vmfs_fetch_e state_q;

  // Decoding.
  wire [15:0] acc_pair   = {high_accumulator, accumulator}; // RQ8
  wire        table_mode = scr_q[SCR_TABLE_BIT]; // RQ9
  wire        slot_open  = (ic_q < SLOT_LIMIT); // RQ1
  wire [2:0]  fifo_count;
  wire        fifo_in_ready;
  wire [2:0]  occupancy  = 3'(fifo_count + {2'b00, pend_fetch_q});
  wire        fifo_room  = (occupancy < FIFO_FULL_OCC) && fifo_in_ready; // RQ7
  wire        fetch_want = (state_q == FS_FETCH) && fifo_room && !field_start; // RQ22
  wire        fetch_gnt  = slot_open && fetch_want; // RQ5
  wire        cpu_gnt    = slot_open && !fetch_want && cpu_req; // RQ5
  wire        last_chr   = (chr_cnt_q == hdisp_q);
  wire        last_scan  = (scan_cnt_q == csh_q); // RQ18
  wire        last_row   = (row_cnt_q == rows_q);
  wire        row_done   = fetch_gnt && last_chr && last_scan;
  wire [15:0] seq_next   = vmfs_next_addr(fetch_ptr_q, wend_q, wbeg_q); // RQ12
  wire [15:0] row_next   = table_mode ? home_q :
                           (row_cnt_q == srb_q) ? status_q : seq_next; // RQ15
  wire        cursor_hit = (fetch_ptr_q == cursor_q); // RQ14
  wire [15:0] rd_word    = attr_ext_en ? mem_rdata : {8'h00, mem_rdata[7:0]}; // RQ3
  wire        h_last     = (h_cnt_q == hlen_q);
  wire [ENTRY_W-1:0] buf_in_data;
  wire [ENTRY_W-1:0] buf_out_data;
  wire        buf_in_valid, buf_in_ready;

  assign cpu_wait      = cpu_req && !cpu_gnt; // RQ6
  assign cpu_ack       = cpu_ack_q;
  assign cpu_rdata     = cpu_rdata_q;
  assign ptr_rdata     = ptr_rdata_q;
  assign mem_addr      = mem_addr_q; // RQ2
  assign mem_rd        = mem_rd_q;
  assign mem_wr        = mem_wr_q;
  assign mem_wdata     = mem_wdata_q;
  assign mem_wide      = attr_ext_en;
  assign mem_mux_mode  = scr_q[SCR_MUX_BIT]; // RQ4
  assign row_end_event = row_end_q;
  assign hsync         = hsync_q;
  assign scan_line     = scan_line_q;
  assign extra_scans   = extra_q;
  assign vid_data      = buf_out_data[DATA_W-1:0];
  assign vid_cursor    = buf_out_data[DATA_W];

  // Instruction cycle slot counter.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ic_q <= '0;
    else
      ic_q <= (ic_q == IC_LAST) ? 3'h0 : 3'(ic_q + 3'h1);
  end

  // Control and pointer registers.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      scr_q <= RST_SCR;
      home_q <= RST_PTR;
      wbeg_q <= RST_PTR;
      wend_q <= RST_PTR;
      cursor_q <= RST_PTR;
      status_q <= RST_PTR;
      ptr_rdata_q <= RST_PTR;
    end
    else
    begin
      if (scr_wr)
        scr_q <= scr_data;
      if (ptr_wr)
      begin
        case (ptr_sel)
          PTR_HOME:   home_q <= acc_pair; // RQ10
          PTR_WBEG:   wbeg_q <= acc_pair;
          PTR_WEND:   wend_q <= acc_pair;
          PTR_CURSOR: cursor_q <= acc_pair;
          PTR_STATUS: status_q <= acc_pair;
          default:    ;
        endcase
      end
      else if (cursor_inc)
        cursor_q <= 16'(cursor_q + 16'h0001); // RQ10
      else if (cursor_dec)
        cursor_q <= 16'(cursor_q - 16'h0001);
      if (ptr_rd)
        ptr_rdata_q <= (ptr_sel == PTR_HOME) ? home_q :
                       (ptr_sel == PTR_CURSOR) ? cursor_q : 16'h0000; // RQ10
    end
  end

  // Timing chain fields.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      hlen_q <= RST_HLEN;
      hdisp_q <= RST_HDISP;
      hsb_q <= RST_HSB;
      hse_q <= RST_HSE;
      csh_q <= RST_CSH;
      es_q <= RST_ES;
      rows_q <= RST_ROWS;
      srb_q <= RST_SRB;
    end
    else if (tc_wr)
    begin
      case (timing_chain_index)
        TC_HLEN:       hlen_q <= tc_data[6:0];
        TC_HDISP:      hdisp_q <= tc_data[6:0];
        TC_HSYNC_BEG:  hsb_q <= tc_data[6:0];
        TC_HSYNC_END:  hse_q <= tc_data[6:0]; // RQ16
        TC_CHAR_HGT:
        begin
          csh_q <= tc_data[CSH_MSB:CSH_LSB]; // RQ18
          es_q  <= tc_data[ES_MSB:ES_LSB]; // RQ19
        end
        TC_DISP_ROWS:  rows_q <= tc_data[4:0];
        TC_STATUS_ROW: srb_q <= tc_data[4:0]; // RQ20
        default:       ;
      endcase
    end
  end

  // Horizontal counter, sync and scan line count.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      h_cnt_q <= '0;
      hsync_q <= 1'b1;
      scan_line_q <= '0;
      extra_q <= '0;
    end
    else
    begin
      h_cnt_q <= h_last ? 7'h00 : 7'(h_cnt_q + 7'h01);
      if (h_cnt_q == hsb_q)
        hsync_q <= 1'b0; // RQ17
      else if (h_cnt_q == hse_q)
        hsync_q <= 1'b1; // RQ16
      if (field_start)
        scan_line_q <= '0;
      else if (h_last)
        scan_line_q <= (scan_line_q == csh_q) ? 4'h0 : 4'(scan_line_q + 4'h1);
      extra_q <= (es_q == csh_q) ? 5'h00 : 5'({1'b0, es_q} + 5'h01); // RQ19
    end
  end

  // Display fetch engine.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= FS_IDLE;
      fetch_ptr_q <= RST_PTR;
      row_start_q <= RST_PTR;
      chr_cnt_q <= '0;
      scan_cnt_q <= '0;
      row_cnt_q <= '0;
      row_end_q <= 1'b0;
    end
    else
    begin
      row_end_q <= row_done; // RQ21
      if (field_start)
      begin
        state_q <= FS_FETCH;
        fetch_ptr_q <= home_q; // RQ11
        row_start_q <= home_q;
        chr_cnt_q <= '0;
        scan_cnt_q <= '0;
        row_cnt_q <= '0;
      end
      else if (fetch_gnt)
      begin
        if (!last_chr)
        begin
          chr_cnt_q <= 7'(chr_cnt_q + 7'h01);
          fetch_ptr_q <= seq_next; // RQ11
        end
        else if (!last_scan)
        begin
          chr_cnt_q <= '0;
          scan_cnt_q <= 4'(scan_cnt_q + 4'h1);
          fetch_ptr_q <= row_start_q;
        end
        else
        begin
          chr_cnt_q <= '0;
          scan_cnt_q <= '0;
          row_cnt_q <= 5'(row_cnt_q + 5'h01);
          row_start_q <= row_next; // RQ21
          fetch_ptr_q <= row_next; // RQ15
          if (last_row)
            state_q <= FS_DONE;
        end
      end
      else
      begin
        case (state_q)
          FS_IDLE, FS_FETCH, FS_DONE: state_q <= state_q;
          default:                    state_q <= FS_IDLE;
        endcase
      end
    end
  end

  // Memory cycle stage and CPU answer.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      pend_fetch_q <= 1'b0;
      pend_cur_q <= 1'b0;
      pend_cpu_q <= 1'b0;
      cpu_ack_q <= 1'b0;
      cpu_rdata_q <= '0;
    end
    else
    begin
      mem_addr_q <= fetch_gnt ? fetch_ptr_q : cpu_addr; // RQ2
      mem_wdata_q <= cpu_wdata;
      mem_rd_q <= fetch_gnt || (cpu_gnt && !cpu_we);
      mem_wr_q <= cpu_gnt && cpu_we;
      pend_fetch_q <= fetch_gnt;
      pend_cur_q <= fetch_gnt && cursor_hit; // RQ14
      pend_cpu_q <= cpu_gnt;
      cpu_ack_q <= pend_cpu_q;
      if (pend_cpu_q && mem_rd_q)
        cpu_rdata_q <= rd_word;
    end
  end

  // Display FIFO followed by the two-entry output buffer.
  vmfs_fifo #(
    .W     (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_disp_fifo (
    .clk       (core_clk),
    .rstn      (rstn),
    .in_valid  (pend_fetch_q),
    .in_data   ({pend_cur_q, rd_word}),
    .in_ready  (fifo_in_ready),
    .out_valid (buf_in_valid),
    .out_data  (buf_in_data),
    .out_ready (buf_in_ready),
    .count     (fifo_count)
  );

  vmfs_fifo #(
    .W     (ENTRY_W),
    .DEPTH (BUF_DEPTH)
  ) u_out_buf (
    .clk       (core_clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_data   (buf_in_data),
    .in_ready  (buf_in_ready),
    .out_valid (vid_valid),
    .out_data  (buf_out_data),
    .out_ready (vid_ready),
    .count     ()
  );

  // Accesses counted per instruction cycle for checking.
  logic [2:0] acc_cnt_q;
  always_ff @(posedge core_clk)
  begin
    if (!rstn || ic_q == 3'h0)
      acc_cnt_q <= {2'b00, (fetch_gnt || cpu_gnt)};
    else
      acc_cnt_q <= 3'(acc_cnt_q + {2'b00, (fetch_gnt || cpu_gnt)});
  end

  property p_slot_limit;
    @(posedge core_clk) disable iff (!rstn) acc_cnt_q <= 3'h3;
  endproperty
  a_slot_limit: assert property (p_slot_limit) else $error("too many accesses"); // RQ1

  property p_fetch_first;
    @(posedge core_clk) disable iff (!rstn)
      (fetch_want && slot_open && cpu_req) |=> (mem_rd_q && !mem_wr_q && !pend_cpu_q);
  endproperty
  a_fetch_first: assert property (p_fetch_first) else $error("cpu beat fetch"); // RQ5

  property p_cpu_wait;
    @(posedge core_clk) disable iff (!rstn)
      (cpu_req && !slot_open) |-> cpu_wait;
  endproperty
  a_cpu_wait: assert property (p_cpu_wait) else $error("cpu not held"); // RQ6

  property p_occupancy;
    @(posedge core_clk) disable iff (!rstn) occupancy <= FIFO_FULL_OCC;
  endproperty
  a_occupancy: assert property (p_occupancy) else $error("fifo overrun"); // RQ7

  property p_field_home;
    @(posedge core_clk) disable iff (!rstn)
      field_start |=> (fetch_ptr_q == $past(home_q)) && (state_q == FS_FETCH);
  endproperty
  a_field_home: assert property (p_field_home) else $error("field not at home"); // RQ11

  property p_wrap;
    @(posedge core_clk) disable iff (!rstn)
      (fetch_gnt && !last_chr && !field_start && 16'(fetch_ptr_q + 16'h0001) == wend_q)
      |=> fetch_ptr_q == $past(wbeg_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // RQ12

  property p_cursor;
    @(posedge core_clk) disable iff (!rstn)
      fetch_gnt |=> pend_cur_q == ($past(fetch_ptr_q) == $past(cursor_q));
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor flag wrong"); // RQ14

  property p_status;
    @(posedge core_clk) disable iff (!rstn)
      (row_done && !field_start && !table_mode && row_cnt_q == srb_q)
      |=> (fetch_ptr_q == $past(status_q)) && (row_start_q == $past(status_q));
  endproperty
  a_status: assert property (p_status) else $error("status jump missed"); // RQ15

  property p_hsync;
    @(posedge core_clk) disable iff (!rstn)
      (h_cnt_q == hse_q && h_cnt_q != hsb_q) |=> hsync_q;
  endproperty
  a_hsync: assert property (p_hsync) else $error("sync end missed"); // RQ17

  property p_request;
    @(posedge core_clk) disable iff (!rstn)
      (state_q == FS_FETCH && fifo_room && slot_open && !field_start)
      |=> mem_rd_q && pend_fetch_q;
  endproperty
  a_request: assert property (p_request) else $error("fetch not requested"); // RQ22
endmodule
`default_nettype wire

// >>> test/vmfs_sequencer_tb_top.sv
// Self-checking bench for the video memory fetch sequencer.
// Assumes the behavioural video memory model on the far side of the bus.
`timescale 1ns/1ps
`default_nettype none
module vmfs_sequencer_tb_top
  import vmfs_pkg::*;
;
  localparam logic [15:0] HOME_A = 16'h00fe;
  localparam logic [15:0] WBEG_A = 16'h0010;
  localparam logic [15:0] WEND_A = 16'h0100;
  localparam logic [15:0] CUR_A  = 16'h00ff;
  localparam logic [15:0] STAT_A = 16'h0200;
  logic        core_clk = 1'b0, rstn = 1'b0, scr_wr = 1'b0, attr_ext_en = 1'b1, tc_wr = 1'b0;
  logic        ptr_wr = 1'b0, ptr_rd = 1'b0, cursor_inc = 1'b0, cursor_dec = 1'b0;
  logic        cpu_req = 1'b0, cpu_we = 1'b0, field_start = 1'b0, vid_ready = 1'b1;
  logic [2:0]  ptr_sel = 3'h0;
  logic [3:0]  timing_chain_index = 4'h0;
  logic [7:0]  scr_data = 8'h00, high_accumulator = 8'h00, accumulator = 8'h00, tc_data = 8'h00;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic [15:0] ptr_rdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, vid_data;
  logic        cpu_wait, cpu_ack, mem_rd, mem_wr, mem_wide, mem_mux_mode, vid_valid, vid_cursor;
  logic        hsync, row_end_event;
  logic [3:0]  scan_line;
  logic [4:0]  extra_scans;
  int          rows_seen = 0;
  logic [4:0]  win_q = 5'h00;
  int          fail_count = 0;
  int          num_checks = 0;

  vmfs_sequencer u_dut (.core_clk, .rstn, .scr_wr, .scr_data, .attr_ext_en, .ptr_wr, .ptr_rd,
    .cursor_inc, .cursor_dec, .ptr_sel, .high_accumulator, .accumulator, .ptr_rdata, .tc_wr,
    .timing_chain_index, .tc_data, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_wait, .cpu_ack,
    .cpu_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_wide, .mem_mux_mode,
    .field_start, .vid_valid, .vid_data, .vid_cursor, .vid_ready, .row_end_event, .hsync,
    .scan_line, .extra_scans);
  vmfs_vidmem u_mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  always #20 core_clk = ~core_clk;

  // Any five consecutive clocks hold at most three memory cycles.
  always @(posedge core_clk)
  begin
    win_q <= {win_q[3:0], mem_rd === 1'b1 || mem_wr === 1'b1};
    if (row_end_event === 1'b1)
      rows_seen++;
    if (rstn && $countones(win_q) > 3)
    begin
      fail_count++;
      $display("BAD %0t too many memory cycles", $time);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tcw(input logic [3:0] i, input logic [7:0] d);
    @(posedge core_clk);
    timing_chain_index <= i;
    tc_data <= d;
    tc_wr <= 1'b1;
    @(posedge core_clk);
    tc_wr <= 1'b0;
  endtask

  task automatic scrw(input logic [7:0] d);
    @(posedge core_clk);
    scr_data <= d;
    scr_wr <= 1'b1;
    @(posedge core_clk);
    scr_wr <= 1'b0;
  endtask

  task automatic ptrw(input logic [2:0] s, input logic [15:0] v);
    @(posedge core_clk);
    ptr_sel <= s;
    high_accumulator <= v[15:8];
    accumulator <= v[7:0];
    ptr_wr <= 1'b1;
    @(posedge core_clk);
    ptr_wr <= 1'b0;
  endtask

  task automatic ptrr(input logic [2:0] s, input logic [15:0] exp, input string what);
    @(posedge core_clk);
    ptr_sel <= s;
    ptr_rd <= 1'b1;
    @(posedge core_clk);
    ptr_rd <= 1'b0;
    #1;
    chk(ptr_rdata, exp, what);
  endtask

  task automatic cursor_pointer(input logic up);
    @(posedge core_clk);
    cursor_inc <= up;
    cursor_dec <= !up;
    @(posedge core_clk);
    cursor_inc <= 1'b0;
    cursor_dec <= 1'b0;
  endtask

  // CPU memory access: request held until granted, then dropped.
  task automatic cpu(input logic we, input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] exp);
    int n;
    @(posedge core_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    n = 0;
    do begin @(negedge core_clk); n++; end while (cpu_wait !== 1'b0 && n < 500);
    @(posedge core_clk);
    cpu_req <= 1'b0;
    #1;
    chk(mem_addr, a, "cpu address");
    for (n = 0; n < 3 && cpu_ack !== 1'b1; n++) begin @(posedge core_clk); #1; end
    chk(16'(cpu_ack), 16'h0001, "cpu ack");
    if (!we)
      chk(cpu_rdata, exp, "cpu read");
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] a);
    return (16'(a + 16'h0001) == WEND_A) ? WBEG_A : 16'(a + 16'h0001);
  endfunction

  // One field of two rows, two scan lines a row, four characters a line.
  task automatic field(input logic stall, input logic [4:0] srb_v, input logic tbl);
    logic [15:0] rs, a, q[$];
    int n, r0;
    rs = HOME_A;
    r0 = rows_seen;
    for (int r = 0; r < 2; r++)
    begin
      for (int l = 0; l < 2; l++)
      begin
        a = rs;
        for (int c = 0; c < 4; c++)
        begin
          q.push_back(a);
          a = nxt(a);
        end
      end
      rs = tbl ? HOME_A : (5'(r) == srb_v) ? STAT_A : a;
    end
    @(posedge core_clk);
    field_start <= 1'b1;
    @(posedge core_clk);
    field_start <= 1'b0;
    if (stall)
    begin
      n = 0;
      repeat (150) begin @(negedge core_clk); if (mem_rd === 1'b1) n++; end
      chk(16'(n), 16'h0006, "fetches while stalled");
      @(posedge core_clk);
      vid_ready <= 1'b1;
    end
    foreach (q[i])
    begin
      n = 0;
      do begin @(negedge core_clk); n++; end
        while (!(vid_valid === 1'b1 && vid_ready === 1'b1) && n < 2000);
      chk(16'(n < 2000), 16'h0001, "stream stalled");
      chk(vid_data, attr_ext_en ? (q[i] ^ 16'ha5c3) : {8'h00, q[i][7:0] ^ 8'hc3}, "data");
      chk(16'(vid_cursor), 16'(q[i] == CUR_A), "cursor flag");
    end
    chk(16'(rows_seen - r0), 16'h0002, "row ends");
  endtask

  initial
  begin
    #(40 * 30000);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    complete_run;
  end

  initial
  begin
    int n;
    logic [3:0] sl;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk(16'(hsync), 16'h0001, "hsync idle");
    chk(16'(vid_valid || mem_rd || mem_wr), 16'h0000, "idle after reset");
    ptrr(PTR_HOME, 16'h0000, "home reset");
    $display("test reset done");
    ptrw(PTR_HOME, HOME_A);
    ptrw(PTR_WBEG, WBEG_A);
    ptrw(PTR_WEND, WEND_A);
    ptrw(PTR_CURSOR, CUR_A);
    ptrw(PTR_STATUS, STAT_A);
    ptrr(PTR_HOME, HOME_A, "home");
    ptrr(PTR_WBEG, 16'h0000, "write only");
    cursor_pointer(1'b1);
    ptrr(PTR_CURSOR, 16'h0100, "cursor up");
    cursor_pointer(1'b0);
    ptrr(PTR_CURSOR, CUR_A, "cursor down");
    $display("test pointers done");
    tcw(TC_HSYNC_END, 8'h4c);
    repeat (80) @(negedge core_clk);
    sl = scan_line;
    n = 0;
    repeat (80) begin @(negedge core_clk); if (hsync === 1'b0) n++; end
    chk(16'(n), 16'(7'h4c - RST_HSB), "sync low span");
    chk(16'(scan_line), (sl == RST_CSH) ? 16'h0000 : 16'(sl + 4'h1), "scan line");
    $display("test sync done");
    tcw(TC_HDISP, 8'h03);
    tcw(TC_CHAR_HGT, 8'h10);
    tcw(TC_DISP_ROWS, 8'h01);
    tcw(TC_STATUS_ROW, 8'h1f);
    scrw(8'h10);
    repeat (2) @(negedge core_clk);
    chk(16'(extra_scans), 16'h0001, "extra scans");
    chk(16'(mem_mux_mode), 16'h0001, "mux mode");
    @(posedge core_clk);
    vid_ready <= 1'b0;
    field(1'b1, 5'h1f, 1'b0);
    $display("test stalled field done");
    tcw(TC_STATUS_ROW, 8'h00);
    fork
      field(1'b0, 5'h00, 1'b0);
      cpu(1'b1, 16'h0400, 16'h1234, 16'h0000);
    join
    cpu(1'b0, 16'h0400, 16'h0000, 16'h1234);
    $display("test status field done");
    tcw(TC_STATUS_ROW, 8'h1f);
    scrw(8'h20);
    @(posedge core_clk);
    attr_ext_en <= 1'b0;
    @(negedge core_clk);
    chk(16'(mem_wide), 16'h0000, "narrow words");
    chk(16'(mem_mux_mode), 16'h0000, "mux mode off");
    field(1'b0, 5'h1f, 1'b1);
    tcw(TC_CHAR_HGT, 8'h11);
    repeat (2) @(negedge core_clk);
    chk(16'(extra_scans), 16'h0000, "no extra scans");
    $display("test table field done");
    complete_run;
  end
endmodule
`default_nettype wire

// >>> test/vmfs_vidmem.sv
// Behavioural video memory on the 16-bit system bus.
// Assumes read data is taken at the edge that ends the read strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module vmfs_vidmem (
  // Bus from the sequencer.
  input  wire logic        core_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata
);
  logic [15:0] store [logic [15:0]];
  logic [15:0] last_q = 16'h0000;
  always @(posedge core_clk)
  begin
    if (mem_wr === 1'b1)
      store[mem_addr] = mem_wdata;
    last_q <= mem_rdata;
  end
  // Unwritten words hold an address pattern; an idle bus shows the inverse of the last word.
  always @*
  begin
    if (mem_rd === 1'b1)
      mem_rdata = store.exists(mem_addr) ? store[mem_addr] : (mem_addr ^ 16'ha5c3);
    else
      mem_rdata = ~last_q;
  end
endmodule
`default_nettype wire
